// *** core/asc_reg_map.svh ***
`ifndef ASC_REG_MAP_SVH
`define ASC_REG_MAP_SVH

// Register indices; byte address is four times the index
`define ASC_IDX_SETUP_FIRST   8'h19
`define ASC_IDX_SETUP_LAST    8'h20
`define ASC_IDX_SELECT        8'h40
`define ASC_IDX_ACTIVE        8'h41
`define ASC_IDX_EFF_GAIN      8'h42

// Field positions in a setup word
`define ASC_EXC_B_HI          15
`define ASC_EXC_B_LO          13
`define ASC_EXC_A_HI          12
`define ASC_EXC_A_LO          10
`define ASC_BURN_HI           9
`define ASC_BURN_LO           8
`define ASC_REF_POS_BIT       7
`define ASC_REF_NEG_BIT       6
`define ASC_REF_SEL_HI        5
`define ASC_REF_SEL_LO        4
`define ASC_GAIN_HI           3
`define ASC_GAIN_LO           1
`define ASC_BYPASS_BIT        0

// Reset and fixed values
`define ASC_SETUP_RESET       16'h0000
`define ASC_UNITY_GAIN_CODE   3'h0
`define ASC_SELECT_RESET      3'h0
`define ASC_WAIT_CYCLES       2'h1

`endif

// *** core/asc_pkg.sv ***
`default_nettype none

package asc_pkg;

	typedef logic [15:0] asc_word_type;
	typedef logic [2:0]  asc_index_type;

	typedef enum logic [1:0] {
		asc_ref_ext_a    = 2'b00,
		asc_ref_ext_b    = 2'b01,
		asc_ref_internal = 2'b10,
		asc_ref_supply   = 2'b11
	} asc_ref_type;

	typedef enum logic [1:0] {
		asc_bus_idle = 2'b00,
		asc_bus_wait = 2'b01,
		asc_bus_done = 2'b10
	} asc_bus_state_type;

endpackage : asc_pkg

`default_nettype wire

// *** core/asc_setup_reg.sv ***
`include "asc_reg_map.svh"
`default_nettype none

module asc_setup_reg #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	// Write port
	input  wire logic             write_en,
	input  wire logic [WIDTH-1:0] write_data,
	// Stored word
	output logic      [WIDTH-1:0] value
);

	// Every field is plain read/write; gain code is kept even under bypass
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			value <= `ASC_SETUP_RESET;
		end else if (write_en) begin
			value <= write_data;
		end
	end

endmodule : asc_setup_reg

`default_nettype wire

// *** core/asc_setup_bank.sv ***
`include "asc_reg_map.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Eight setup words at consecutive indices, all zero after reset.
// - Bits 15..13 hold excitation source B level; zero is off, seven smallest.
// - Bits 12..10 hold excitation source A level, same coding as source B.
// - Bits 9..8 hold burnout current code; zero off, higher codes larger.
// - Bit 7 set turns positive reference buffer on, clear bypasses it.
// - Bit 6 set turns negative reference buffer on, clear bypasses it.
// - Bits 5..4 select reference: pair A, pair B, internal, supply rails.
// - Bits 3..1 give gain code k, gain two to the power k.
// - Bit 0 set enables gain bypass, clear disables it.
// - With bypass set the gain code is ignored and unity gain applies.
// - A setup drives the front end only when the channel or the software override selects it.
module asc_setup_bank #(
	parameter int NUM_SETUPS = 8
) (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	// Avalon-MM slave
	input  wire logic [9:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	output logic      [1:0]            avs_response,
	// Setup chosen by the channel sequencer
	input  wire asc_pkg::asc_index_type chan_setup_sel,
	input  wire logic                  chan_setup_valid,
	// Active setup to the analog front end
	output logic      [2:0]            excite_src_b_level,
	output logic      [2:0]            excite_src_a_level,
	output logic      [1:0]            burnout_level,
	output logic                       ref_pos_buffer_on,
	output logic                       ref_neg_buffer_on,
	output var asc_pkg::asc_ref_type    ref_source,
	output logic      [2:0]            gain_code,
	output logic                       gain_bypass,
	output logic      [2:0]            applied_gain_code,
	output logic                       front_end_active
);
	import asc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	asc_bus_state_type state;
	asc_bus_state_type next_state;
	logic [7:0]        index;
	logic              in_bank;
	logic              hit_select;
	logic              hit_active;
	logic              hit_eff_gain;
	logic              mapped;
	logic              access;
	logic              lanes_low;
	logic [2:0]        slot;
	logic [2:0]        sw_select;
	logic              sw_override;
	asc_word_type      words [NUM_SETUPS];
	asc_word_type      write_word;
	asc_word_type      active_word;
	asc_index_type     active_sel;
	logic              active_valid;
	logic [2:0]        eff_gain;
	logic [31:0]       read_mux;
	logic [NUM_SETUPS-1:0] write_hit;

	assign index        = avs_address[9:2];
	assign in_bank      = (index >= `ASC_IDX_SETUP_FIRST) && (index <= `ASC_IDX_SETUP_LAST);
	assign slot         = 3'(index - `ASC_IDX_SETUP_FIRST);
	assign hit_select   = (index == `ASC_IDX_SELECT);
	assign hit_active   = (index == `ASC_IDX_ACTIVE);
	assign hit_eff_gain = (index == `ASC_IDX_EFF_GAIN);
	assign mapped       = in_bank | hit_select | hit_active | hit_eff_gain;
	assign access       = (avs_read | avs_write) && (state == asc_bus_idle);
	assign lanes_low    = avs_byteenable[1] & avs_byteenable[0];

	// Only full low-halfword writes land, so a field is never half updated
	assign write_word   = avs_writedata[15:0];

	////////////////////////////////////////////////////////////////////////////
	// Handshake: one wait cycle from asc_bus_idle, two from asc_bus_done; answer in the cycle after the wait
	always_comb begin
		next_state = state;
		case (state)
			asc_bus_idle: begin
				if (avs_read | avs_write) begin
					next_state = asc_bus_wait;
				end
			end
			asc_bus_wait: next_state = asc_bus_done;
			asc_bus_done: next_state = asc_bus_idle;
			default:      next_state = asc_bus_idle;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= asc_bus_idle;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Setup word storage
	genvar g;
	generate
		for (g = 0; g < NUM_SETUPS; g++) begin : gen_setup
			assign write_hit[g] = (state == asc_bus_wait) && avs_write && in_bank && lanes_low
			                      && (slot == 3'(g));
			asc_setup_reg #(.WIDTH(16)) u_setup (
				.sys_clk    (sys_clk),
				.rst_b      (rst_b),
				.write_en   (write_hit[g]),
				.write_data (write_word),
				.value      (words[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Software override of the selection, for bring-up without the sequencer
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sw_select   <= `ASC_SELECT_RESET;
			sw_override <= 1'b0;
		end else if ((state == asc_bus_wait) && avs_write && hit_select && avs_byteenable[0]) begin
			sw_select   <= avs_writedata[2:0];
			sw_override <= avs_writedata[4];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Active setup selection
	assign active_sel   = sw_override ? sw_select : chan_setup_sel;
	assign active_valid = sw_override | chan_setup_valid;
	assign active_word  = active_valid ? words[active_sel] : `ASC_SETUP_RESET;
	assign eff_gain     = active_word[`ASC_BYPASS_BIT] ? `ASC_UNITY_GAIN_CODE
	                      : active_word[`ASC_GAIN_HI:`ASC_GAIN_LO];

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			excite_src_b_level <= 3'h0;
			excite_src_a_level <= 3'h0;
			burnout_level      <= 2'h0;
			ref_pos_buffer_on  <= 1'b0;
			ref_neg_buffer_on  <= 1'b0;
			ref_source         <= asc_ref_ext_a;
			gain_code          <= 3'h0;
			gain_bypass        <= 1'b0;
			applied_gain_code  <= 3'h0;
			front_end_active   <= 1'b0;
		end else begin
			excite_src_b_level <= active_word[`ASC_EXC_B_HI:`ASC_EXC_B_LO];
			excite_src_a_level <= active_word[`ASC_EXC_A_HI:`ASC_EXC_A_LO];
			burnout_level      <= active_word[`ASC_BURN_HI:`ASC_BURN_LO];
			ref_pos_buffer_on  <= active_word[`ASC_REF_POS_BIT];
			ref_neg_buffer_on  <= active_word[`ASC_REF_NEG_BIT];
			ref_source         <= asc_ref_type'(active_word[`ASC_REF_SEL_HI:`ASC_REF_SEL_LO]);
			gain_code          <= active_word[`ASC_GAIN_HI:`ASC_GAIN_LO];
			gain_bypass        <= active_word[`ASC_BYPASS_BIT];
			applied_gain_code  <= eff_gain;
			front_end_active   <= active_valid;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read path
	always_comb begin
		read_mux = 32'h0000_0000;
		if (in_bank) begin
			read_mux = {16'h0000, words[slot]};
		end else if (hit_select) begin
			read_mux = {27'h000_0000, sw_override, 1'b0, sw_select};
		end else if (hit_active) begin
			read_mux = {16'h0000, active_word};
		end else if (hit_eff_gain) begin
			read_mux = {28'h000_0000, active_valid, eff_gain};
		end
	end

	// Unmapped addresses answer with a slave error and zero data
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			avs_readdata    <= 32'h0000_0000;
			avs_waitrequest <= 1'b1;
			avs_response    <= 2'h0;
		end else begin
			avs_waitrequest <= !((state == asc_bus_idle) && access);
			if ((state == asc_bus_idle) && access) begin
				avs_readdata <= (avs_read && mapped) ? read_mux : 32'h0000_0000;
				avs_response <= mapped ? 2'h0 : 2'h2;
			end
		end
	end

endmodule : asc_setup_bank

`default_nettype wire

// *** tb/asc_setup_bank_asserts.sv ***
`include "asc_reg_map.svh"
`default_nettype none

module asc_setup_bank_asserts #(
	parameter int NUM_SETUPS = 8
) (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_b,
	// Bus
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic [9:0]  avs_address,
	input wire logic [31:0] avs_readdata,
	input wire logic [1:0]  avs_response,
	// Front end
	input wire logic        chan_setup_valid,
	input wire logic        ref_pos_buffer_on,
	input wire logic        ref_neg_buffer_on,
	input wire logic        gain_bypass,
	input wire logic        front_end_active,
	input wire logic [2:0]  excite_src_b_level,
	input wire logic [2:0]  excite_src_a_level,
	input wire logic [1:0]  burnout_level,
	input wire logic [2:0]  gain_code,
	input wire logic [2:0]  applied_gain_code,
	input wire logic [1:0]  ref_source
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	chk_wait_one: assert property ($fell(avs_waitrequest) |=> avs_waitrequest) else $error("wait low too long");
	chk_idle_high: assert property (!avs_read && !avs_write |=> avs_waitrequest) else $error("answer without request");
	chk_req_answer: assert property (avs_read || avs_write |-> ##[0:2] !avs_waitrequest) else $error("no answer");
	chk_bypass_unity: assert property (gain_bypass |-> applied_gain_code == 3'h0) else $error("bypass gain");
	chk_gain_pass: assert property (!gain_bypass |-> applied_gain_code == gain_code) else $error("gain");
	chk_idle_zero: assert property (!front_end_active |->
		{excite_src_b_level, excite_src_a_level, burnout_level, ref_pos_buffer_on, ref_neg_buffer_on, ref_source,
		gain_code, gain_bypass} == 16'h0000) else $error("idle");
	chk_sel_active: assert property (chan_setup_valid |=> front_end_active) else $error("not active");
	chk_upper_zero: assert property (avs_read && !avs_waitrequest |->
		avs_readdata[31:16] == 16'h0000) else $error("upper bits");
	chk_setup_ok: assert property (!avs_waitrequest && avs_address[9:2] >= `ASC_IDX_SETUP_FIRST
		&& avs_address[9:2] <= `ASC_IDX_SETUP_LAST |-> avs_response == 2'b00) else $error("setup refused");
endmodule : asc_setup_bank_asserts

bind asc_setup_bank asc_setup_bank_asserts #(.NUM_SETUPS(NUM_SETUPS)) chk (.sys_clk(sys_clk), .rst_b(rst_b),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
	.avs_readdata(avs_readdata), .avs_response(avs_response), .burnout_level(burnout_level),
	.chan_setup_valid(chan_setup_valid), .ref_pos_buffer_on(ref_pos_buffer_on), .ref_neg_buffer_on(ref_neg_buffer_on),
	.gain_bypass(gain_bypass), .front_end_active(front_end_active), .excite_src_b_level(excite_src_b_level),
	.excite_src_a_level(excite_src_a_level), .gain_code(gain_code), .applied_gain_code(applied_gain_code),
	.ref_source(ref_source));

`default_nettype wire

// *** tb/tb_asc_setup_bank.sv ***
`include "asc_reg_map.svh"
`default_nettype none

module tb_asc_setup_bank;
	timeunit 1ns;
	timeprecision 1ps;
	import asc_pkg::*;
	logic sys_clk = 0, rst_b = 0, avs_read = 0, avs_write = 0, chan_setup_valid = 0, rp, rn, gb, fa, wq;
	logic [9:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, rd, avs_readdata;
	logic [3:0] avs_byteenable = 4'hf;
	logic [1:0] rsp, avs_response, bl;
	logic [2:0] xb, xa, gc, ag;
	asc_index_type chan_setup_sel = 0;
	asc_ref_type rs;
	int err_total = 0, n_compared = 0, cyc = 0;

	asc_setup_bank dut (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(wq), .avs_response(avs_response),
		.chan_setup_sel(chan_setup_sel), .chan_setup_valid(chan_setup_valid), .excite_src_b_level(xb),
		.excite_src_a_level(xa), .burnout_level(bl), .ref_pos_buffer_on(rp), .ref_neg_buffer_on(rn),
		.ref_source(rs), .gain_code(gc), .gain_bypass(gb), .applied_gain_code(ag), .front_end_active(fa));

	always #12.5 sys_clk = ~sys_clk;
	// Ceiling well above the under two hundred cycles the tests need
	always @(posedge sys_clk) if (++cyc == 3000) begin
		err_total++;
		tally_and_finish();
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Outputs are read right after the edge, before its updates land
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd, input logic [3:0] be);
		@(posedge sys_clk);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {16'h0000, wd};
		avs_byteenable <= be;
		do @(posedge sys_clk); while (wq !== 1'b0);
		rd = avs_readdata;
		rsp = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	function automatic logic [15:0] pat(input int i);
		return {i[2:0], 3'(7 - i), i[1:0], i[0], ~i[0], i[1:0], i[2:0], 1'b0};
	endfunction : pat

	task automatic sel_chk(input int i, input logic [15:0] w);
		chan_setup_sel <= 3'(i);
		chan_setup_valid <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("src_b", xb, w[15:13]);
		chk("src_a", xa, w[12:10]);
		chk("burnout", bl, w[9:8]);
		chk("ref_bufs", {rp, rn}, w[7:6]);
		chk("ref_sel", rs, w[5:4]);
		chk("gain", {gc, gb}, w[3:0]);
		chk("applied", ag, w[0] ? 3'h0 : w[3:1]);
		chk("active", fa, 1'b1);
	endtask : sel_chk

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		for (int i = 0; i < 8; i++) begin
			bus(0, `ASC_IDX_SETUP_FIRST + 8'(i), 0, 4'hf);
			chk("reset", rd, 0);
		end
		bus(0, 8'h18, 0, 4'hf);
		chk("below", rsp, 2'b10);
		bus(1, 8'h21, 16'hffff, 4'hf);
		chk("above", rsp, 2'b10);
		$display("test reset done");
	endtask : t_reset

	task automatic t_fields;
		for (int i = 0; i < 8; i++) bus(1, `ASC_IDX_SETUP_FIRST + 8'(i), pat(i), 4'hf);
		bus(1, `ASC_IDX_SETUP_FIRST, 16'hffff, 4'h1);
		for (int i = 0; i < 8; i++) begin
			bus(0, `ASC_IDX_SETUP_FIRST + 8'(i), 0, 4'hf);
			chk("readback", rd, pat(i));
			sel_chk(i, pat(i));
		end
		$display("test fields done");
	endtask : t_fields

	task automatic t_bypass;
		bus(1, `ASC_IDX_SETUP_FIRST + 8'h5, 16'h000b, 4'hf);
		sel_chk(5, 16'h000b);
		bus(0, `ASC_IDX_SETUP_FIRST + 8'h5, 0, 4'hf);
		chk("kept", rd, 16'h000b);
		bus(1, `ASC_IDX_SETUP_FIRST + 8'h5, 16'h000a, 4'hf);
		sel_chk(5, 16'h000a);
		chan_setup_valid <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("idle", {fa, xb, xa, bl, rp, rn, rs, gc, gb, ag}, 0);
		$display("test bypass done");
	endtask : t_bypass

	// Software override forces setup 3 while the sequencer is idle
	task automatic t_override;
		logic [15:0] w;
		w = pat(3);
		bus(1, `ASC_IDX_SELECT, 16'h0013, 4'hf);
		chk("sel_resp", rsp, 2'b00);
		repeat (3) @(posedge sys_clk);
		chk("forced", {fa, xb, xa, bl, rp, rn, rs, gc, gb}, {1'b1, w[15:1], w[0]});
		bus(0, `ASC_IDX_SELECT, 0, 4'hf);
		chk("sel_reg", rd, 32'h0000_0013);
		bus(0, `ASC_IDX_ACTIVE, 0, 4'hf);
		chk("active_word", rd, {16'h0000, w});
		chk("active_resp", rsp, 2'b00);
		bus(0, `ASC_IDX_EFF_GAIN, 0, 4'hf);
		chk("eff_gain", rd, {1'b1, (w[0] ? 3'h0 : w[3:1])});
		bus(1, `ASC_IDX_SELECT, 16'h0000, 4'hf);
		repeat (3) @(posedge sys_clk);
		chk("released", fa, 1'b0);
		$display("test override done");
	endtask : t_override

	// A reset in mid-run must clear words written earlier
	task automatic t_rereset;
		@(posedge sys_clk);
		rst_b <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		bus(0, `ASC_IDX_SETUP_FIRST + 8'h3, 0, 4'hf);
		chk("rereset", rd, 0);
		chk("rereset_resp", rsp, 2'b00);
		$display("test rereset done");
	endtask : t_rereset

	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_reset();
		t_fields();
		t_bypass();
		t_override();
		t_rereset();
		tally_and_finish();
	end
endmodule : tb_asc_setup_bank

`default_nettype wire
